// >>> verilog/servo_input_pkg.sv
// package: register map, field positions, reset values and carriers of the input decoder
`default_nettype none
package servo_input_pkg;
   // register byte addresses
   localparam logic [5:0] ADDR_FIRST_SETUP = 6'h00;
   localparam logic [5:0] ADDR_SECOND_SETUP = 6'h04;
   localparam logic [5:0] ADDR_SPEED_SCALE = 6'h08;
   localparam logic [5:0] ADDR_TORQUE_SCALE = 6'h0c;
   localparam logic [5:0] ADDR_LOCK_SPEED = 6'h10;
   localparam logic [5:0] ADDR_INT_SPEED_ONE = 6'h14;
   localparam logic [5:0] ADDR_INT_SPEED_TWO = 6'h18;
   localparam logic [5:0] ADDR_INT_SPEED_THREE = 6'h1c;
   localparam logic [5:0] ADDR_STATUS = 6'h20;
   // first setup word fields
   localparam int FS_AUTO_RUN = 0;
   localparam int FS_ENC_IGNORE = 1;
   localparam int FS_FWD_IGNORE = 2;
   localparam int FS_REV_IGNORE = 3;
   localparam int FS_MF_LO = 10;
   localparam int FS_MF_HI = 11;
   // second setup word field
   localparam int SS_INT_SPEED = 2;
   // scales in millivolts
   localparam logic [13:0] TORQUE_SCALE_MIN = 14'd1000;
   localparam logic [13:0] TORQUE_SCALE_MAX = 14'd10000;
   localparam logic [13:0] SPEED_SCALE_MIN = 14'd2000;
   localparam logic [13:0] SPEED_SCALE_MAX = 14'd10000;
   // reset values
   localparam logic [15:0] FIRST_SETUP_RST = 16'h0000;
   localparam logic [15:0] SECOND_SETUP_RST = 16'h0000;
   localparam logic [13:0] TORQUE_SCALE_RST = 14'd3000;
   localparam logic [13:0] SPEED_SCALE_RST = 14'd10000;
   localparam logic [15:0] LOCK_SPEED_RST = 16'h000a;
   // rated torque or rated speed as a signed count
   localparam int RATED_SHIFT = 12;

   // multifunction input use, selected by bits b and A
   typedef enum logic [1:0] {
      MF_GAIN = 2'b00,
      MF_LOCK = 2'b01,
      MF_NONE = 2'b10,
      MF_MODE = 2'b11
   } mfUse_t;

   // discrete control inputs
   typedef struct packed {
      logic run;
      logic alarmReset;
      logic encoderPowerRequest;
      logic dualUse0;
      logic dualUse1;
      logic multifunction;
      logic forwardTravelAllowed;
      logic reverseTravelAllowed;
   } ctlPins_t;

   // decoded control requests
   typedef struct packed {
      logic servoEnable;
      logic encoderPower;
      logic forwardCurrentLimitRequest;
      logic reverseCurrentLimitRequest;
      logic [1:0] internalSpeedSelect;
      logic internalSpeedDirection;
      logic gainReductionRequest;
      logic positionLockRequest;
      logic torqueMode;
      logic forwardProhibit;
      logic reverseProhibit;
      logic driverHealthyOutput;
   } driveCtl_t;
endpackage : servo_input_pkg
`default_nettype wire

// >>> verilog/servo_control_input_decode.sv
// control-connector input decoder with a classic Wishbone register slave
`default_nettype none
module servo_control_input_decode #(
   parameter int LEVEL_W = 16
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [5:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   input wire servo_input_pkg::ctlPins_t pins,
   input wire logic signed [LEVEL_W-1:0] torqueCommandLevel,
   input wire logic signed [LEVEL_W-1:0] speedCommandLevel,
   input wire logic signed [15:0] motorSpeed,
   input wire logic alarmRaise,
   output servo_input_pkg::driveCtl_t ctl,
   output logic signed [15:0] torqueCommand,
   output logic signed [15:0] speedTarget,
   output logic signed [15:0] speedLimit
);
   import servo_input_pkg::*;

   if (LEVEL_W < 8 || LEVEL_W > 16) begin : g_bad_width
      $error("LEVEL_W must lie between 8 and 16");
   end

   typedef struct packed {
      logic ack;
      logic [31:0] rdData;
      logic [15:0] firstSetup;
      logic [15:0] secondSetup;
      logic [13:0] speedScale;
      logic [13:0] torqueScale;
      logic [15:0] lockSpeed;
      logic [2:0][15:0] intSpeed;
      logic alarm;
      driveCtl_t ctl;
      logic signed [15:0] torqueCmd;
      logic signed [15:0] speedTgt;
      logic signed [15:0] speedLim;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // level in millivolts over scale in millivolts, rated equals 1 << RATED_SHIFT
   function automatic logic signed [15:0] scaleLevel(input logic signed [LEVEL_W-1:0] lvl,
                                                     input logic [13:0] sc);
      logic signed [31:0] num;
      logic signed [31:0] quo;
      num = 32'(lvl) <<< RATED_SHIFT;
      quo = num / $signed({18'h00000, sc});
      if (quo > 32'sd32767) begin
         scaleLevel = 16'sh7fff;
      end else if (quo < -32'sd32767) begin
         scaleLevel = 16'sh8001; // symmetric, so its magnitude always fits
      end else begin
         scaleLevel = quo[15:0];
      end
   endfunction : scaleLevel

   // limit a written scale to its legal span
   function automatic logic [13:0] clampScale(input logic [31:0] d, input logic [13:0] lo,
                                              input logic [13:0] hi);
      if (d < {18'h00000, lo}) begin
         clampScale = lo;
      end else if (d > {18'h00000, hi}) begin
         clampScale = hi;
      end else begin
         clampScale = d[13:0];
      end
   endfunction : clampScale

   // byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      merge16 = old;
      if (sel[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (sel[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction : merge16

   ////////////////////////////////////////////////////////////////////////////
   // combinational next state

   logic req;
   logic wrTake;
   logic intSpeedMode;
   mfUse_t mfUse;
   logic [15:0] speedMag;
   logic signed [15:0] speedScaled;
   logic [31:0] rdMux;

   always_comb begin
      st_nxt = st_r;
      req = wbCyc && wbStb;
      wrTake = req && wbWe && !st_r.ack;
      intSpeedMode = st_r.secondSetup[SS_INT_SPEED];
      mfUse = mfUse_t'(st_r.firstSetup[FS_MF_HI:FS_MF_LO]);
      speedMag = motorSpeed[15] ? 16'(-motorSpeed) : motorSpeed;
      speedScaled = scaleLevel(speedCommandLevel, st_r.speedScale);
      rdMux = 32'h00000000;

      // bus answer one cycle after the request, dropped the cycle after
      st_nxt.ack = req && !st_r.ack;
      unique case (wbAdr)
         ADDR_FIRST_SETUP: rdMux = {16'h0000, st_r.firstSetup};
         ADDR_SECOND_SETUP: rdMux = {16'h0000, st_r.secondSetup};
         ADDR_SPEED_SCALE: rdMux = {18'h00000, st_r.speedScale};
         ADDR_TORQUE_SCALE: rdMux = {18'h00000, st_r.torqueScale};
         ADDR_LOCK_SPEED: rdMux = {16'h0000, st_r.lockSpeed};
         ADDR_INT_SPEED_ONE: rdMux = {16'h0000, st_r.intSpeed[0]};
         ADDR_INT_SPEED_TWO: rdMux = {16'h0000, st_r.intSpeed[1]};
         ADDR_INT_SPEED_THREE: rdMux = {16'h0000, st_r.intSpeed[2]};
         ADDR_STATUS: rdMux = {17'h00000, st_r.alarm, pins, 6'h00} | {19'h00000, st_r.ctl};
         default: rdMux = 32'h00000000;
      endcase
      st_nxt.rdData = (req && !st_r.ack && !wbWe) ? rdMux : 32'h00000000;

      // register writes take effect as the answer is given
      if (wrTake) begin
         unique case (wbAdr)
            ADDR_FIRST_SETUP: st_nxt.firstSetup = merge16(st_r.firstSetup, wbDatIn, wbSel);
            ADDR_SECOND_SETUP: st_nxt.secondSetup = merge16(st_r.secondSetup, wbDatIn, wbSel);
            ADDR_SPEED_SCALE: begin
               if (wbSel[1:0] == 2'b11) begin
                  st_nxt.speedScale = clampScale(wbDatIn, SPEED_SCALE_MIN, SPEED_SCALE_MAX);
               end
            end
            ADDR_TORQUE_SCALE: begin
               if (wbSel[1:0] == 2'b11) begin
                  st_nxt.torqueScale = clampScale(wbDatIn, TORQUE_SCALE_MIN, TORQUE_SCALE_MAX);
               end
            end
            ADDR_LOCK_SPEED: st_nxt.lockSpeed = merge16(st_r.lockSpeed, wbDatIn, wbSel);
            ADDR_INT_SPEED_ONE: st_nxt.intSpeed[0] = merge16(st_r.intSpeed[0], wbDatIn, wbSel);
            ADDR_INT_SPEED_TWO: st_nxt.intSpeed[1] = merge16(st_r.intSpeed[1], wbDatIn, wbSel);
            ADDR_INT_SPEED_THREE: st_nxt.intSpeed[2] = merge16(st_r.intSpeed[2], wbDatIn, wbSel);
            default: st_nxt.firstSetup = st_r.firstSetup;
         endcase
      end

      // alarm latch, a new alarm wins over a reset in the same cycle
      if (alarmRaise) begin
         st_nxt.alarm = 1'b1;
      end else if (pins.alarmReset) begin
         st_nxt.alarm = 1'b0;
      end
      st_nxt.ctl.driverHealthyOutput = !(alarmRaise || st_nxt.alarm);

      // servo on and encoder supply
      st_nxt.ctl.servoEnable = (st_r.firstSetup[FS_AUTO_RUN] || pins.run)
         && !st_nxt.alarm;
      st_nxt.ctl.encoderPower = !st_r.firstSetup[FS_ENC_IGNORE]
         && pins.encoderPowerRequest;

      // overtravel prohibits
      st_nxt.ctl.forwardProhibit = !st_r.firstSetup[FS_FWD_IGNORE]
         && !pins.forwardTravelAllowed;
      st_nxt.ctl.reverseProhibit = !st_r.firstSetup[FS_REV_IGNORE]
         && !pins.reverseTravelAllowed;

      // dual-use inputs
      st_nxt.ctl.forwardCurrentLimitRequest = !intSpeedMode && pins.dualUse0;
      st_nxt.ctl.reverseCurrentLimitRequest = !intSpeedMode && pins.dualUse1;
      st_nxt.ctl.internalSpeedSelect = intSpeedMode ? {pins.dualUse1, pins.dualUse0}
         : 2'b00;

      // multifunction input
      st_nxt.ctl.internalSpeedDirection = 1'b0;
      st_nxt.ctl.gainReductionRequest = 1'b0;
      st_nxt.ctl.positionLockRequest = 1'b0;
      st_nxt.ctl.torqueMode = 1'b0;
      if (intSpeedMode) begin
         st_nxt.ctl.internalSpeedDirection = pins.multifunction;
      end else begin
         unique case (mfUse)
            MF_GAIN: st_nxt.ctl.gainReductionRequest = pins.multifunction;
            MF_LOCK: st_nxt.ctl.positionLockRequest = pins.multifunction
               && (speedMag <= st_r.lockSpeed);
            MF_MODE: st_nxt.ctl.torqueMode = !pins.multifunction;
            MF_NONE: st_nxt.ctl.torqueMode = 1'b0;
         endcase
      end

      // analog commands
      st_nxt.torqueCmd = scaleLevel(torqueCommandLevel, st_r.torqueScale);
      if (intSpeedMode) begin
         unique case (st_nxt.ctl.internalSpeedSelect)
            2'b00: st_nxt.speedTgt = 16'sh0000;
            2'b01: st_nxt.speedTgt = $signed(st_r.intSpeed[0]);
            2'b10: st_nxt.speedTgt = $signed(st_r.intSpeed[1]);
            2'b11: st_nxt.speedTgt = $signed(st_r.intSpeed[2]);
         endcase
         if (pins.multifunction) begin
            st_nxt.speedTgt = 16'(-st_nxt.speedTgt);
         end
         st_nxt.speedLim = 16'sh7fff;
      end else if (st_nxt.ctl.torqueMode) begin
         st_nxt.speedTgt = 16'sh0000;
         st_nxt.speedLim = speedScaled[15] ? 16'(-speedScaled) : speedScaled;
      end else begin
         st_nxt.speedTgt = speedScaled;
         st_nxt.speedLim = 16'sh7fff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.firstSetup <= FIRST_SETUP_RST;
         st_r.secondSetup <= SECOND_SETUP_RST;
         st_r.speedScale <= SPEED_SCALE_RST;
         st_r.torqueScale <= TORQUE_SCALE_RST;
         st_r.lockSpeed <= LOCK_SPEED_RST;
         st_r.speedLim <= 16'sh7fff;
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   assign wbAck = st_r.ack;
   assign wbDatOut = st_r.rdData;
   assign ctl = st_r.ctl;
   assign torqueCommand = st_r.torqueCmd;
   assign speedTarget = st_r.speedTgt;
   assign speedLimit = st_r.speedLim;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   a_servo_run_gate: assert property (clkEn && !st_r.firstSetup[0] && !pins.run
      |=> !ctl.servoEnable) else $error("servo enabled without run");
   a_servo_auto_on: assert property (clkEn && st_r.firstSetup[0] && !alarmRaise
      && !st_r.alarm && !pins.alarmReset |=> ctl.servoEnable)
      else $error("automatic servo on missing");
   a_encoder_ignore: assert property (clkEn && st_r.firstSetup[1]
      |=> !ctl.encoderPower) else $error("encoder request not ignored");
   a_current_limit: assert property (clkEn && !st_r.secondSetup[2]
      |=> ctl.forwardCurrentLimitRequest == $past(pins.dualUse0)
      && ctl.internalSpeedSelect == 2'b00) else $error("current limit decode wrong");
   a_speed_select: assert property (clkEn && st_r.secondSetup[2]
      |=> ctl.internalSpeedSelect == $past({pins.dualUse1, pins.dualUse0})
      && !ctl.reverseCurrentLimitRequest) else $error("internal speed select wrong");
   a_direction_wins: assert property (clkEn && st_r.secondSetup[2]
      |=> ctl.internalSpeedDirection == $past(pins.multifunction)
      && !ctl.gainReductionRequest && !ctl.positionLockRequest && !ctl.torqueMode)
      else $error("direction use not given priority");
   a_gain_reduce: assert property (clkEn && !st_r.secondSetup[2]
      && st_r.firstSetup[11:10] == 2'b00 && pins.multifunction
      |=> ctl.gainReductionRequest) else $error("gain reduction missing");
   a_lock_speed: assert property (clkEn && !st_r.secondSetup[2]
      && st_r.firstSetup[11:10] == 2'b01 && pins.multifunction
      |=> ctl.positionLockRequest == ($past(speedMag) <= $past(st_r.lockSpeed)))
      else $error("position lock speed gate wrong");
   a_mode_switch: assert property (clkEn && !st_r.secondSetup[2]
      && st_r.firstSetup[11:10] == 2'b11 |=> ctl.torqueMode != $past(pins.multifunction))
      else $error("torque speed switch wrong");
   a_mf_ignored: assert property (clkEn && !st_r.secondSetup[2]
      && st_r.firstSetup[11:10] == 2'b10 |=> !ctl.gainReductionRequest
      && !ctl.positionLockRequest && !ctl.torqueMode) else $error("reserved use not ignored");
   a_torque_limit: assert property (ctl.torqueMode
      |-> speedTarget == 16'sh0000 && !speedLimit[15])
      else $error("torque mode speed limit wrong");
   a_fwd_prohibit: assert property (clkEn && !st_r.firstSetup[2]
      |=> ctl.forwardProhibit == !$past(pins.forwardTravelAllowed))
      else $error("forward prohibit wrong");
   a_rev_prohibit: assert property (clkEn && st_r.firstSetup[3]
      |=> !ctl.reverseProhibit) else $error("reverse travel not ignored");
   a_alarm_clear: assert property (clkEn && pins.alarmReset && !alarmRaise
      |=> ##[0:1] ctl.driverHealthyOutput) else $error("alarm reset ineffective");
   a_alarm_drop: assert property (clkEn && alarmRaise
      |=> !ctl.driverHealthyOutput && !ctl.servoEnable) else $error("healthy not dropped");
   a_scale_span: assert property (st_r.torqueScale >= 14'd1000
      && st_r.torqueScale <= 14'd10000 && st_r.speedScale >= 14'd2000)
      else $error("scale out of span");
   a_bus_ack: assert property (wbAck && clkEn |=> !wbAck) else $error("ack held two cycles");
endmodule : servo_control_input_decode
`default_nettype wire

// >>> dv/host_ctl_model.sv
// host motion controller model that drives the control connector pins
`default_nettype none
module host_ctl_model (
   input wire logic clk_sys,
   input wire servo_input_pkg::ctlPins_t reqPins,
   input wire logic [3:0] lag,
   output var servo_input_pkg::ctlPins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   import servo_input_pkg::*;
   logic [3:0] waitCnt;
   // idle levels before the host starts commanding
   initial begin
      pins = '0;
      waitCnt = '0;
   end
   // new levels land lag plus one cycles after the host decides on them
   always @(posedge clk_sys) begin
      if (reqPins == pins) waitCnt <= '0;
      else if (waitCnt >= lag) pins <= reqPins;
      else waitCnt <= waitCnt + 4'h1;
   end
endmodule : host_ctl_model
`default_nettype wire

// >>> dv/servo_control_input_decode_test.sv
// self-checking bench for the control input decoder
`default_nettype none
module servo_control_input_decode_test;
   timeunit 1ns;
   timeprecision 1ps;
   import servo_input_pkg::*;
   logic clk_sys, sys_rst, clkEn, wbCyc, wbStb, wbWe, wbAck, alarmRaise, mAlarm;
   logic [5:0] wbAdr;
   logic [3:0] wbSel, lag;
   logic [31:0] wbDatIn, wbDatOut, q;
   ctlPins_t reqPins, pins, p;
   driveCtl_t ctl, e;
   logic signed [15:0] torqueCommandLevel, speedCommandLevel, motorSpeed;
   logic signed [15:0] torqueCommand, speedTarget, speedLimit, ex;
   logic signed [15:0] spd [3];
   logic [15:0] fs, ss;
   int fails, num_checks, seed, i, r, r2;
   //////////////////////////////////////////////////////////////
   // design, far-side host and clock
   servo_control_input_decode dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .pins(pins),
      .torqueCommandLevel(torqueCommandLevel), .speedCommandLevel(speedCommandLevel),
      .motorSpeed(motorSpeed), .alarmRaise(alarmRaise), .ctl(ctl),
      .torqueCommand(torqueCommand), .speedTarget(speedTarget), .speedLimit(speedLimit));
   host_ctl_model host (.clk_sys(clk_sys), .reqPins(reqPins), .lag(lag), .pins(pins));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // alarm latch of the reference model: raise wins over reset
   always @(posedge clk_sys) begin
      if (sys_rst) mAlarm <= 1'b0;
      else if (clkEn && alarmRaise) mAlarm <= 1'b1;
      else if (clkEn && pins.alarmReset) mAlarm <= 1'b0;
   end
   //////////////////////////////////////////////////////////////
   // reference decode of the control requests
   function automatic driveCtl_t expCtl(ctlPins_t c, logic [15:0] f, logic [15:0] s,
         logic al, logic signed [15:0] ms);
      driveCtl_t x;
      logic [1:0] u;
      int mag;
      x = '0;
      u = s[2] ? 2'b10 : f[11:10];
      mag = (ms < 0) ? -int'(ms) : int'(ms);
      x.servoEnable = (f[0] | c.run) & !al;
      x.encoderPower = c.encoderPowerRequest & !f[1];
      x.forwardCurrentLimitRequest = !s[2] & c.dualUse0;
      x.reverseCurrentLimitRequest = !s[2] & c.dualUse1;
      x.internalSpeedSelect = s[2] ? {c.dualUse1, c.dualUse0} : 2'b00;
      x.internalSpeedDirection = s[2] & c.multifunction;
      x.gainReductionRequest = (u == 2'b00) & c.multifunction;
      x.positionLockRequest = (u == 2'b01) & c.multifunction & (mag <= int'(LOCK_SPEED_RST));
      x.torqueMode = (u == 2'b11) & !c.multifunction;
      x.forwardProhibit = !f[2] & !c.forwardTravelAllowed;
      x.reverseProhibit = !f[3] & !c.reverseTravelAllowed;
      x.driverHealthyOutput = !al;
      return x;
   endfunction : expCtl
   //////////////////////////////////////////////////////////////
   // compare, bus cycles, settling and verdict
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatIn <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      check("bus ack", 32'h1, {31'h0, wbAck});
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge clk_sys);
   endtask : wb
   task automatic settle();
      repeat (int'(lag) + 4) @(posedge clk_sys);
   endtask : settle
   task automatic results();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   initial begin
      repeat (60000) @(posedge clk_sys);
      $display("[FAIL] watchdog expected finish seen hang");
      fails++;
      results();
   end
   //////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed = 32'hbae4;
      fails = 0;
      num_checks = 0;
      {clkEn, sys_rst, wbCyc, wbStb, wbWe, alarmRaise} = 6'h30;
      {wbAdr, wbSel, wbDatIn, lag, fs, ss} = {6'h0, 4'hf, 32'h0, 4'h0, 32'h0};
      {reqPins, torqueCommandLevel, speedCommandLevel, motorSpeed} = '0;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      wb(1'b0, ADDR_SPEED_SCALE, 32'h0);
      check("speed scale reset", {18'h0, SPEED_SCALE_RST}, q);
      wb(1'b0, ADDR_LOCK_SPEED, 32'h0);
      check("lock speed reset", {16'h0, LOCK_SPEED_RST}, q);
      wb(1'b1, 6'h24, 32'hffff);
      wb(1'b0, 6'h24, 32'h0);
      check("unmapped read", 32'h0, q);
      $display("test registers done");
      for (i = 0; i < 80; i++) begin
         r = $random(seed);
         r2 = $random(seed);
         fs = r[15:0] & 16'h0c0f;
         ss = {13'h0, r[16], 2'b00};
         wb(1'b1, ADDR_FIRST_SETUP, {16'h0, fs});
         wb(1'b1, ADDR_SECOND_SETUP, {16'h0, ss});
         reqPins <= r[31:24];
         lag <= {1'b0, r[19:17]};
         motorSpeed <= 16'(r2 % 21);
         alarmRaise <= r2[20];
         @(posedge clk_sys);
         alarmRaise <= 1'b0;
         settle();
         e = expCtl(reqPins, fs, ss, mAlarm, motorSpeed);
         check("ctl", 32'(e), 32'(ctl));
      end
      $display("test decode done");
      // a low clock enable holds ctl, then the status word reads back
      clkEn <= 1'b0;
      reqPins <= ~reqPins;
      settle();
      check("frozen ctl", 32'(e), 32'(ctl));
      clkEn <= 1'b1;
      settle();
      e = expCtl(reqPins, fs, ss, mAlarm, motorSpeed);
      check("thawed ctl", 32'(e), 32'(ctl));
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("status", {17'h0, mAlarm, reqPins, 6'h00} | {19'h0, e}, q);
      $display("test freeze and status done");
      lag <= 4'h0;
      wb(1'b1, ADDR_TORQUE_SCALE, 32'd500);
      wb(1'b0, ADDR_TORQUE_SCALE, 32'h0);
      check("torque scale clamp", {18'h0, TORQUE_SCALE_MIN}, q);
      wb(1'b1, ADDR_SPEED_SCALE, 32'd12000);
      wb(1'b0, ADDR_SPEED_SCALE, 32'h0);
      check("speed scale clamp", {18'h0, SPEED_SCALE_MAX}, q);
      wb(1'b1, ADDR_SPEED_SCALE, 32'd8000);
      wb(1'b1, ADDR_FIRST_SETUP, 32'h0);
      wb(1'b1, ADDR_SECOND_SETUP, 32'h0);
      reqPins <= 8'h03;
      torqueCommandLevel <= 16'sd1000;
      speedCommandLevel <= -16'sd8000;
      settle();
      check("torque command", 32'sd4096, torqueCommand);
      check("speed target", -32'sd4096, speedTarget);
      check("speed limit", 32'sd32767, speedLimit);
      torqueCommandLevel <= 16'sd20000;
      wb(1'b1, ADDR_FIRST_SETUP, 32'h0c00);
      speedCommandLevel <= 16'sd4000;
      settle();
      check("torque saturated", 32'sd32767, torqueCommand);
      check("torque mode target", 32'sd0, speedTarget);
      check("torque mode limit", 32'sd2048, speedLimit);
      $display("test analog done");
      spd = '{16'sd100, -16'sd200, 16'sd300};
      wb(1'b1, ADDR_FIRST_SETUP, 32'h0);
      wb(1'b1, ADDR_SECOND_SETUP, 32'h4);
      for (i = 0; i < 3; i++) wb(1'b1, ADDR_INT_SPEED_ONE + 6'(4 * i), 32'(spd[i]));
      for (i = 0; i < 6; i++) begin
         p = 8'h03;
         {p.dualUse1, p.dualUse0} = 2'(i % 3 + 1);
         p.multifunction = (i >= 3);
         reqPins <= p;
         settle();
         ex = (i >= 3) ? -spd[i % 3] : spd[i % 3];
         check("internal speed", 32'(ex), 32'(speedTarget));
      end
      $display("test internal speed done");
      // a second reset clears the outputs except speedLimit, which it sets to 7fff, and restores the register defaults
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check("ctl in reset", 32'h0, 32'(ctl));
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      wb(1'b0, ADDR_SECOND_SETUP, 32'h0);
      check("second setup after reset", {16'h0, SECOND_SETUP_RST}, q);
      $display("test second reset done");
      results();
   end
endmodule : servo_control_input_decode_test
`default_nettype wire
